// file: hw/lct_top.sv
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module lct_top (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   external_rollover_input,
  input  wire logic                   overlong_period_event,
  input  wire logic                   ar_request_enabled,
  input  wire logic                   rx_cycle_start,
  output lct_pkg::lct_ctrl_s          ctrl_out,
  output logic [11:0]                 cycle_offset,
  output logic                        cycle_rollover,
  output logic                        cycle_start_send,
  output logic                        phy_packet_accept,
  output logic                        selfid_packet_accept,
  output logic                        iso_tag_one_force
);
  import lct_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state.

  logic        aw_got_ff;
  logic        nxt_aw_got;
  logic [7:0]  waddr_ff;
  logic [7:0]  nxt_waddr;
  logic        w_got_ff;
  logic        nxt_w_got;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic [3:0]  wstrb_ff;
  logic [3:0]  nxt_wstrb;
  logic        awready_ff;
  logic        nxt_awready;
  logic        wready_ff;
  logic        nxt_wready;
  logic        bvalid_ff;
  logic        nxt_bvalid;
  logic [1:0]  bresp_ff;
  logic [1:0]  nxt_bresp;
  logic        arready_ff;
  logic        nxt_arready;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0]  rresp_ff;
  logic [1:0]  nxt_rresp;
  logic        wr_fire;
  logic [31:0] set_mask;
  logic [31:0] clr_mask;
  logic [31:0] lane_mask;
  logic [31:0] ctrl_word;

  lct_ctrl_s   ctrl_ff;
  lct_ctrl_s   nxt_ctrl;

  // Readback word; every bit not listed here stays zero.
  always_comb
  begin
    ctrl_word                 = LCT_RST_DATA;
    ctrl_word[LCT_BIT_SRC]    = ctrl_ff.rollover_origin_select;
    ctrl_word[LCT_BIT_MASTER] = ctrl_ff.root_timing_master;
    ctrl_word[LCT_BIT_RUN]    = ctrl_ff.timer_offset_run;
    ctrl_word[LCT_BIT_PHY]    = ctrl_ff.accept_phy_packets;
    ctrl_word[LCT_BIT_SELFID] = ctrl_ff.accept_selfid_packets;
    ctrl_word[LCT_BIT_LOCK]   = ctrl_ff.tag_one_filter_force;
  end

  // Write and read channels. Address and data are caught in either order and
  // the write lands one cycle after both are held, together with bvalid.
  always_comb
  begin
    nxt_aw_got  = aw_got_ff | (s_axi_awvalid & awready_ff);
    nxt_waddr   = (s_axi_awvalid & awready_ff) ? s_axi_awaddr : waddr_ff;
    nxt_w_got   = w_got_ff | (s_axi_wvalid & wready_ff);
    nxt_wdata   = (s_axi_wvalid & wready_ff) ? s_axi_wdata : wdata_ff;
    nxt_wstrb   = (s_axi_wvalid & wready_ff) ? s_axi_wstrb : wstrb_ff;
    nxt_bvalid  = bvalid_ff & ~s_axi_bready;
    nxt_bresp   = bresp_ff;
    wr_fire     = aw_got_ff & w_got_ff & ~bvalid_ff;
    if (wr_fire)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = (waddr_ff == LCT_OFS_SET || waddr_ff == LCT_OFS_CLR) ?
                   LCT_RESP_OKAY : LCT_RESP_SLVERR;
    end
    // Ready drops while a channel is held so only one write is in flight.
    nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
    nxt_wready  = ~nxt_w_got & ~nxt_bvalid;

    nxt_rvalid  = rvalid_ff & ~s_axi_rready;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (s_axi_arvalid & arready_ff)
    begin
      nxt_rvalid = 1'b1;
      if (s_axi_araddr == LCT_OFS_SET || s_axi_araddr == LCT_OFS_CLR)
      begin
        nxt_rdata = ctrl_word;
        nxt_rresp = LCT_RESP_OKAY;
      end
      else
      begin
        nxt_rdata = LCT_RST_DATA;
        nxt_rresp = LCT_RESP_SLVERR;
      end
    end
    nxt_arready = ~nxt_rvalid;
  end

  // Byte lanes not strobed leave their bits alone.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      lane_mask[i*8 +: 8] = {8{wstrb_ff[i]}};
    end
    set_mask = (wr_fire && waddr_ff == LCT_OFS_SET) ? (wdata_ff & lane_mask) : '0;
    clr_mask = (wr_fire && waddr_ff == LCT_OFS_CLR) ? (wdata_ff & lane_mask) : '0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff  <= 1'b0;
      waddr_ff   <= 8'h00;
      w_got_ff   <= 1'b0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= LCT_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= LCT_RESP_OKAY;
    end
    else
    begin
      aw_got_ff  <= nxt_aw_got;
      waddr_ff   <= nxt_waddr;
      w_got_ff   <= nxt_w_got;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register.

  logic overlong_prev_ff;
  logic nxt_overlong_prev;

  // The master bit may not come back while the event flag is still high, so
  // a software set and a hardware clear can never fight in one cycle.
  always_comb
  begin
    nxt_overlong_prev = overlong_period_event;
    nxt_ctrl          = ctrl_ff;
    nxt_ctrl.rollover_origin_select =
      (ctrl_ff.rollover_origin_select | set_mask[LCT_BIT_SRC]) & ~clr_mask[LCT_BIT_SRC];
    nxt_ctrl.timer_offset_run =
      (ctrl_ff.timer_offset_run | set_mask[LCT_BIT_RUN]) & ~clr_mask[LCT_BIT_RUN];
    nxt_ctrl.accept_phy_packets =
      (ctrl_ff.accept_phy_packets | set_mask[LCT_BIT_PHY]) & ~clr_mask[LCT_BIT_PHY];
    nxt_ctrl.accept_selfid_packets =
      (ctrl_ff.accept_selfid_packets | set_mask[LCT_BIT_SELFID]) & ~clr_mask[LCT_BIT_SELFID];
    nxt_ctrl.tag_one_filter_force =
      ctrl_ff.tag_one_filter_force | set_mask[LCT_BIT_LOCK];
    nxt_ctrl.root_timing_master =
      (ctrl_ff.root_timing_master | (set_mask[LCT_BIT_MASTER] & ~overlong_period_event))
      & ~clr_mask[LCT_BIT_MASTER]
      & ~(overlong_period_event & ~overlong_prev_ff);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff          <= LCT_CTRL_RST;
      overlong_prev_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff          <= nxt_ctrl;
      overlong_prev_ff <= nxt_overlong_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle timer.

  logic        ext_sync1_ff;
  logic        ext_sync2_ff;
  logic        ext_prev_ff;
  logic [15:0] acc_ff;
  logic [15:0] nxt_acc;
  logic [16:0] acc_sum;
  logic        tick;
  logic [11:0] offset_ff;
  logic [11:0] nxt_offset;
  logic        roll_ff;
  logic        nxt_roll;
  logic        start_ff;
  logic        nxt_start;
  logic        ext_edge;

  // Rate accumulator gives 24576 ticks per 40000 clocks, so one 125 us cycle
  // holds exactly 3072 ticks without a second clock domain.
  always_comb
  begin
    acc_sum = {1'b0, acc_ff} + {1'b0, LCT_ACC_STEP};
    tick    = (acc_sum >= {1'b0, LCT_ACC_MOD});
    nxt_acc = tick ? 16'(acc_sum - {1'b0, LCT_ACC_MOD}) : acc_sum[15:0];
  end

  // Offset counting and rollover selection.
  always_comb
  begin
    ext_edge   = ext_sync2_ff & ~ext_prev_ff;
    nxt_offset = offset_ff;
    nxt_roll   = 1'b0;
    if (ctrl_ff.timer_offset_run)
    begin
      if (ctrl_ff.rollover_origin_select)
      begin
        if (ext_edge)
        begin
          nxt_offset = 12'h000;
          nxt_roll   = 1'b1;
        end
        else if (tick)
        begin
          nxt_offset = offset_ff + 12'h001;
        end
      end
      else if (tick)
      begin
        if (offset_ff >= LCT_OFFSET_LAST)
        begin
          nxt_offset = 12'h000;
          nxt_roll   = 1'b1;
        end
        else
        begin
          nxt_offset = offset_ff + 12'h001;
        end
      end
    end
    // A follower realigns its offset to the sender of cycle starts.
    if (!ctrl_ff.root_timing_master && rx_cycle_start)
    begin
      nxt_offset = 12'h000;
    end
    nxt_start = nxt_roll & ctrl_ff.root_timing_master;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_sync1_ff <= 1'b0;
      ext_sync2_ff <= 1'b0;
      ext_prev_ff  <= 1'b0;
      acc_ff       <= 16'h0000;
      offset_ff    <= 12'h000;
      roll_ff      <= 1'b0;
      start_ff     <= 1'b0;
    end
    else
    begin
      ext_sync1_ff <= external_rollover_input;
      ext_sync2_ff <= ext_sync1_ff;
      ext_prev_ff  <= ext_sync2_ff;
      acc_ff       <= nxt_acc;
      offset_ff    <= nxt_offset;
      roll_ff      <= nxt_roll;
      start_ff     <= nxt_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive gating, registered so every output leaves a flip-flop.

  logic phy_acc_ff;
  logic selfid_acc_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phy_acc_ff    <= 1'b0;
      selfid_acc_ff <= 1'b0;
    end
    else
    begin
      phy_acc_ff    <= ctrl_ff.accept_phy_packets & ar_request_enabled;
      selfid_acc_ff <= ctrl_ff.accept_selfid_packets;
    end
  end

  // Outputs; the force level overrides each context's own filter bit when
  // high and leaves it to software when low.
  assign s_axi_awready        = awready_ff;
  assign s_axi_wready         = wready_ff;
  assign s_axi_bvalid         = bvalid_ff;
  assign s_axi_bresp          = bresp_ff;
  assign s_axi_arready        = arready_ff;
  assign s_axi_rvalid         = rvalid_ff;
  assign s_axi_rdata          = rdata_ff;
  assign s_axi_rresp          = rresp_ff;
  assign ctrl_out             = ctrl_ff;
  assign cycle_offset         = offset_ff;
  assign cycle_rollover       = roll_ff;
  assign cycle_start_send     = start_ff;
  assign phy_packet_accept    = phy_acc_ff;
  assign selfid_packet_accept = selfid_acc_ff;
  assign iso_tag_one_force    = ctrl_ff.tag_one_filter_force;

endmodule // lct_top

`default_nettype wire

// file: hw/lct_pkg.sv
package lct_pkg;

  // Register map, byte addresses on the 32-bit bus.
  localparam logic [7:0]  LCT_OFS_SET       = 8'hE0;
  localparam logic [7:0]  LCT_OFS_CLR       = 8'hE4;

  // Field positions inside the link control word.
  localparam int          LCT_BIT_SRC       = 22;
  localparam int          LCT_BIT_MASTER    = 21;
  localparam int          LCT_BIT_RUN       = 20;
  localparam int          LCT_BIT_PHY       = 10;
  localparam int          LCT_BIT_SELFID    = 9;
  localparam int          LCT_BIT_LOCK      = 6;

  // Reset values; the undefined bits are brought up as zero.
  localparam logic        LCT_RST_SRC       = 1'b0;
  localparam logic        LCT_RST_MASTER    = 1'b0;
  localparam logic        LCT_RST_RUN       = 1'b0;
  localparam logic [31:0] LCT_RST_DATA      = 32'h0000_0000;

  // Timing: the 24.576 MHz timer rate is made from aclk by a rate accumulator.
  localparam int          LCT_CLK_KHZ       = 40000;
  localparam int          LCT_TICK_KHZ      = 24576;
  localparam int          LCT_CYCLE_US      = 125;
  localparam int          LCT_ROLL_TICKS    = LCT_TICK_KHZ * LCT_CYCLE_US / 1000;
  localparam logic [11:0] LCT_OFFSET_LAST   = 12'(LCT_ROLL_TICKS - 1);
  localparam logic [15:0] LCT_ACC_STEP      = 16'(LCT_TICK_KHZ);
  localparam logic [15:0] LCT_ACC_MOD       = 16'(LCT_CLK_KHZ);

  // AXI4-Lite response codes.
  localparam logic [1:0]  LCT_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  LCT_RESP_SLVERR   = 2'h2;

  // Software-visible control state of the link.
  typedef struct packed {
    logic rollover_origin_select;
    logic root_timing_master;
    logic timer_offset_run;
    logic accept_phy_packets;
    logic accept_selfid_packets;
    logic tag_one_filter_force;
  } lct_ctrl_s;

  localparam lct_ctrl_s   LCT_CTRL_RST      = '{LCT_RST_SRC, LCT_RST_MASTER, LCT_RST_RUN,
                                                1'b0, 1'b0, 1'b0};

endpackage

// file: verification/lct_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// Port-level checks of the link control register and its cycle timer.
module lct_top_sva (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               external_rollover_input,
  input wire logic               overlong_period_event,
  input wire logic               ar_request_enabled,
  input wire logic               rx_cycle_start,
  input wire lct_pkg::lct_ctrl_s ctrl_out,
  input wire logic [11:0]        cycle_offset,
  input wire logic               cycle_rollover,
  input wire logic               cycle_start_send,
  input wire logic               phy_packet_accept,
  input wire logic               selfid_packet_accept,
  input wire logic               iso_tag_one_force
);
  import lct_pkg::*;
  // One clock domain, so clock and reset are given once for all checks.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_rsvd_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFF8F_F9BF) == 32'h0)
    else $error("Reserved bits read nonzero.");
  a_phy_gate: assert property (phy_packet_accept == $past(ctrl_out.accept_phy_packets && ar_request_enabled))
    else $error("PHY accept does not follow bit and context enable.");
  a_selfid_gate: assert property (selfid_packet_accept == $past(ctrl_out.accept_selfid_packets))
    else $error("Self-ID accept does not follow its bit.");
  a_lock_level: assert property (iso_tag_one_force == ctrl_out.tag_one_filter_force)
    else $error("Filter force differs from lock bit.");
  a_lock_sticky: assert property (ctrl_out.tag_one_filter_force |=> ctrl_out.tag_one_filter_force)
    else $error("Lock bit cleared without reset.");
  a_start_roll: assert property (cycle_start_send |-> cycle_rollover && $past(ctrl_out.root_timing_master))
    else $error("Cycle start without rollover as master.");
  a_roll_zero: assert property (cycle_rollover |-> cycle_offset == 12'h000)
    else $error("Offset not zero at rollover.");
  a_roll_count: assert property (cycle_rollover && !$past(ctrl_out.rollover_origin_select) |-> $past(cycle_offset) == 12'hBFF)
    else $error("Internal rollover not after 3072 ticks.");
  a_ext_roll: assert property ($rose(external_rollover_input) && ctrl_out.rollover_origin_select && ctrl_out.timer_offset_run |-> ##[1:5] cycle_rollover)
    else $error("External edge gave no rollover.");
  a_offset_hold: assert property ($past(!ctrl_out.timer_offset_run) && !$past(rx_cycle_start) |-> $stable(cycle_offset))
    else $error("Offset moved while stopped.");
  a_master_refuse: assert property ($rose(ctrl_out.root_timing_master) |-> !$past(overlong_period_event))
    else $error("Master set while overlong flag high.");
  a_master_clear: assert property ($rose(overlong_period_event) ##1 overlong_period_event |=> !ctrl_out.root_timing_master)
    else $error("Master not cleared by overlong flag.");
  // Main scenarios that the bench is expected to reach.
  c_start: cover property (cycle_start_send);
  c_drop: cover property ($fell(ctrl_out.root_timing_master));
  c_lock: cover property (s_axi_rvalid && s_axi_rdata[6]);
endmodule // lct_top_sva
////////////////////////////////////////////////////////////////
bind lct_top lct_top_sva lct_top_sva_inst (.aclk, .aresetn, .s_axi_rdata, .s_axi_rvalid,
  .external_rollover_input, .overlong_period_event, .ar_request_enabled, .rx_cycle_start,
  .ctrl_out, .cycle_offset, .cycle_rollover, .cycle_start_send, .phy_packet_accept,
  .selfid_packet_accept, .iso_tag_one_force);
`default_nettype wire

// file: verification/lct_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module lct_top_tb;
  import lct_pkg::*;
  logic               aclk = 1'b0;
  logic               aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic               s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic               s_axi_rvalid, external_rollover_input, overlong_period_event;
  logic               ar_request_enabled, rx_cycle_start, cycle_rollover, cycle_start_send;
  logic               phy_packet_accept, selfid_packet_accept, iso_tag_one_force;
  logic [7:0]         s_axi_awaddr, s_axi_araddr;
  logic [31:0]        s_axi_wdata, s_axi_rdata;
  logic [3:0]         s_axi_wstrb;
  logic [1:0]         s_axi_bresp, s_axi_rresp, resp;
  logic [11:0]        cycle_offset, held;
  lct_ctrl_s          ctrl_out;
  int                 fails = 0;
  int                 comparisons = 0;
  int                 n;
  // A 25 ns clock, 40 MHz.
  always #12.5 aclk = ~aclk;
  lct_top lct_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .external_rollover_input, .overlong_period_event,
    .ar_request_enabled, .rx_cycle_start, .ctrl_out, .cycle_offset, .cycle_rollover,
    .cycle_start_send, .phy_packet_accept, .selfid_packet_accept, .iso_tag_one_force);
  ////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Leading edge keeps a new request from landing in the step that ended the last one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && k < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 50) fails++;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && k < 50);
    if (k >= 50) fails++;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_roll(input int lim);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (cycle_rollover !== 1'b1 && n < lim);
  endtask
  ////////////////////////////////////////////////////////////////
  // Hang guard: the longest scenario waits two internal periods of 5000 clocks.
  initial
  begin
    repeat (30000) @(posedge aclk);
    fails++;
    tally_and_finish();
  end
  // Main sequence.
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {external_rollover_input, overlong_period_event, ar_request_enabled, rx_cycle_start} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(LCT_OFS_SET, 32'h0000_0000, LCT_RESP_OKAY);
    rdc(LCT_OFS_CLR, 32'h0000_0000, LCT_RESP_OKAY);
    overlong_period_event <= 1'b1;
    wr(LCT_OFS_SET, 32'hFFFF_FFFF, 4'hF);
    @(negedge aclk);
    chk({31'h0, phy_packet_accept}, 32'h0);
    chk({31'h0, selfid_packet_accept}, 32'h1);
    chk({31'h0, iso_tag_one_force}, 32'h1);
    rdc(LCT_OFS_SET, 32'h0050_0640, LCT_RESP_OKAY);
    rdc(LCT_OFS_CLR, 32'h0050_0640, LCT_RESP_OKAY);
    ar_request_enabled <= 1'b1;
    overlong_period_event <= 1'b0;
    wr(LCT_OFS_SET, 32'h0020_0000, 4'hF);
    @(negedge aclk);
    chk({31'h0, phy_packet_accept}, 32'h1);
    rdc(LCT_OFS_CLR, 32'h0070_0640, LCT_RESP_OKAY);
    // Back to the internal count, or no rollover comes without a pin edge.
    wr(LCT_OFS_CLR, 32'h0040_0000, 4'hF);
    rdc(LCT_OFS_SET, 32'h0030_0640, LCT_RESP_OKAY);
    wait_roll(6000);
    chk({31'h0, cycle_start_send}, 32'h1);
    wait_roll(6000);
    chk(32'(n), 32'd5000);
    @(posedge aclk);
    overlong_period_event <= 1'b1;
    rdc(LCT_OFS_SET, 32'h0010_0640, LCT_RESP_OKAY);
    overlong_period_event <= 1'b0;
    @(posedge aclk);
    rx_cycle_start <= 1'b1;
    @(posedge aclk);
    rx_cycle_start <= 1'b0;
    @(negedge aclk);
    chk({20'h0, cycle_offset}, 32'h0);
    wr(LCT_OFS_CLR, 32'h0010_0000, 4'hF);
    @(negedge aclk);
    held = cycle_offset;
    repeat (40) @(negedge aclk);
    chk({20'h0, cycle_offset}, {20'h0, held});
    wr(LCT_OFS_SET, 32'h0070_0000, 4'hF);
    @(posedge aclk);
    external_rollover_input <= 1'b1;
    wait_roll(8);
    chk({31'h0, cycle_start_send}, 32'h1);
    @(posedge aclk);
    external_rollover_input <= 1'b0;
    wr(LCT_OFS_CLR, 32'hFFFF_FFFF, 4'hF);
    rdc(LCT_OFS_SET, 32'h0000_0040, LCT_RESP_OKAY);
    wr(LCT_OFS_SET, 32'hFFFF_FFFF, 4'h2);
    rdc(LCT_OFS_SET, 32'h0000_0640, LCT_RESP_OKAY);
    wr(8'hE8, 32'hFFFF_FFFF, 4'hF);
    chk({30'h0, resp}, {30'h0, LCT_RESP_SLVERR});
    rdc(8'hE8, 32'h0000_0000, LCT_RESP_SLVERR);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(LCT_OFS_SET, 32'h0000_0000, LCT_RESP_OKAY);
    chk({31'h0, iso_tag_one_force}, 32'h0);
    tally_and_finish();
  end
endmodule // lct_top_tb
`default_nettype wire
